// ---- rtl/pmbus_output_regs.svh ----
// Register offsets, reset values and timing counts for the output command set
// Assumes a 40 MHz core clock
`ifndef PMBUS_OUTPUT_REGS_SVH
`define PMBUS_OUTPUT_REGS_SVH
`define CMD_ON_OFF_CONTROL 8'h01
`define CMD_ON_OFF_SOURCE 8'h02
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_STORE_DEFAULT 8'h11
`define CMD_RESTORE_DEFAULT 8'h12
`define CMD_STORE_USER 8'h15
`define CMD_RESTORE_USER 8'h16
`define CMD_VOLTAGE_MODE 8'h20
`define CMD_TARGET_VOLTAGE 8'h21
`define CMD_VOLTAGE_TRIM 8'h22
`define CMD_CAL_OFFSET 8'h23
`define CMD_VOLTAGE_CEILING 8'h24
`define CMD_MARGIN_HIGH 8'h25
`define CMD_MARGIN_LOW 8'h26
`define CMD_SLEW_RATE 8'h27
`define CMD_LOAD_LINE 8'h28
`define CMD_DUTY_LIMIT 8'h32
`define CMD_SWITCH_FREQ 8'h33
`define CMD_PHASE_GROUP 8'h37
`define OP_IMMEDIATE_OFF 8'h04
`define OP_SOFT_OFF 8'h44
`define OP_ON_NOMINAL 8'h84
`define OP_ON_MARGIN_LOW 8'h94
`define OP_ON_MARGIN_HIGH 8'ha4
`define SRC_ALWAYS_ON 8'h00
`define SRC_PIN_SOFT 8'h16
`define SRC_PIN_IMMEDIATE 8'h17
`define SRC_COMMAND 8'h1a
`define RST_ON_OFF_SOURCE 8'h16
`define RST_ON_OFF_CONTROL 8'h04
`define VOLTAGE_MODE_VALUE 8'h13
`define RST_TRIM 16'h0000
`define RST_SLEW_RATE 16'hba00
`define RST_LOAD_LINE 16'h0000
`define RST_DUTY_LIMIT 16'headb
`define SLEW_FASTEST 16'h7fff
`define VOLT_FOUR 16'h8000
`define DROOP_MAX_MV 16'd40
`define FREQ_MIN_KHZ 16'd400
`define FREQ_MAX_KHZ 16'd1000
`define CLK_HZ 40000000
`define STORE_BUSY_MS 20
`define STORE_BUSY_CYCLES ((`STORE_BUSY_MS * `CLK_HZ) / 1000)
`define SLEW_TICK_US 1
`define SLEW_TICK_CYCLES ((`SLEW_TICK_US * `CLK_HZ) / 1000000)
`endif

// ---- rtl/pmbus_output_pkg.sv ----
// Types for the output command set
// Used with pmbus_output_regs.svh
package pmbus_output_pkg;
  typedef enum logic [1:0] {rx_idle, rx_cmd, rx_lo, rx_hi} rx_state_e;
  typedef enum logic [1:0] {mem_idle, mem_store, mem_restore} mem_state_e;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {level_nominal, level_low, level_high} vsel_e;
endpackage

// ---- rtl/pmbus_output_command_set.sv ----
// Output control command decoder and settings store, with SMBus slave
// Assumes scl and sda pins resolved outside; strap inputs steady after reset
`timescale 1ns/100ps
`include "pmbus_output_regs.svh"
module pmbus_output_command_set
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [6:0] bus_address,
  input wire logic enable_pin,
  input wire logic power_present,
  input wire logic [15:0] strap_voltage,
  input wire logic [15:0] strap_frequency,
  input wire logic [15:0] strap_phase_group_placement,
  input wire logic [7:0] fault_conditions,
  output logic [7:0] fault_status,
  output logic output_on,
  output logic immediate_off,
  output logic [15:0] voltage_setpoint,
  output logic signed [16:0] voltage_offset,
  output logic [15:0] droop_setting,
  output logic [15:0] duty_limit,
  output logic [15:0] frequency_setting,
  output logic [3:0] group_number,
  output logic [4:0] rails_in_group,
  output logic [3:0] group_position,
  output logic [1:0] security_level,
  output logic busy
);
  localparam int NREG = 12;
  localparam logic [31:0] BUSY_CYCLES = 32'(`STORE_BUSY_CYCLES);
  localparam logic [7:0] TICK_CYCLES = 8'(`SLEW_TICK_CYCLES);

  logic [2:0] scl_s_q, sda_s_q;
  logic scl_rise, scl_fall, start_c, stop_c;
  pmbus_output_pkg::rx_state_e rx_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, cmd_q, lo_q, hi_q;
  logic addr_ok_q, rd_q, ack_q, in_frame_q, send_q, sending_q;
  logic [15:0] tx_q;
  logic [1:0] bytes_q;
  logic wr_byte, wr_word, wr_send;

  // Two-flop sync plus one history stage for edges
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
    end
  end
  assign scl_rise = scl_s_q[1] && !scl_s_q[2];
  assign scl_fall = !scl_s_q[1] && scl_s_q[2];
  assign start_c = scl_s_q[1] && scl_s_q[2] && !sda_s_q[1] && sda_s_q[2];
  assign stop_c = scl_s_q[1] && scl_s_q[2] && sda_s_q[1] && !sda_s_q[2];

  // Operating memory
  logic [7:0] onoff_q, src_q;
  pmbus_output_pkg::word_t regs_q [NREG];
  pmbus_output_pkg::word_t dflt_q [NREG];
  pmbus_output_pkg::word_t user_q [NREG];
  logic user_valid_q, dflt_valid_q;
  logic [7:0] onoff_dflt_q, src_dflt_q, onoff_user_q, src_user_q;
  localparam int I_TGT = 0, I_TRIM = 1, I_CAL = 2, I_MAX = 3, I_MH = 4, I_ML = 5;
  localparam int I_SLEW = 6, I_DROOP = 7, I_DUTY = 8, I_FREQ = 9, I_ILV = 10, I_SPARE = 11;

  function automatic int cmd_index(input logic [7:0] c);
    unique case (c)
      `CMD_TARGET_VOLTAGE: cmd_index = I_TGT;
      `CMD_VOLTAGE_TRIM: cmd_index = I_TRIM;
      `CMD_CAL_OFFSET: cmd_index = I_CAL;
      `CMD_VOLTAGE_CEILING: cmd_index = I_MAX;
      `CMD_MARGIN_HIGH: cmd_index = I_MH;
      `CMD_MARGIN_LOW: cmd_index = I_ML;
      `CMD_SLEW_RATE: cmd_index = I_SLEW;
      `CMD_LOAD_LINE: cmd_index = I_DROOP;
      `CMD_DUTY_LIMIT: cmd_index = I_DUTY;
      `CMD_SWITCH_FREQ: cmd_index = I_FREQ;
      `CMD_PHASE_GROUP: cmd_index = I_ILV;
      default: cmd_index = I_SPARE;
    endcase
  endfunction

  // Linear-11 decode to integer, exponent 5-bit signed
  function automatic logic signed [31:0] l11_int(input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [31:0] m;
    e = w[15:11];
    m = 32'(signed'(w[10:0]));
    l11_int = (e < 0) ? (m >>> (-e)) : (m <<< e);
  endfunction

  // Strap-derived limits, unsigned fixed-exponent words
  logic [17:0] strap_110, strap_105, strap_095;
  assign strap_110 = 18'((28'(strap_voltage) * 28'd11) / 28'd10);
  assign strap_105 = 18'((28'(strap_voltage) * 28'd21) / 28'd20);
  assign strap_095 = 18'((28'(strap_voltage) * 28'd19) / 28'd20);

  function automatic logic [15:0] sat16(input logic [17:0] v);
    sat16 = (v > 18'h0ffff) ? 16'hffff : v[15:0];
  endfunction

  logic [15:0] wr_val;
  logic [15:0] tgt_cap;
  assign wr_val = {hi_q, lo_q};
  // Target clamp to ceiling and 110% of strap
  always_comb
  begin
    tgt_cap = wr_val;
    if (tgt_cap > regs_q[I_MAX])
      tgt_cap = regs_q[I_MAX];
    if (18'(tgt_cap) > strap_110)
      tgt_cap = sat16(strap_110);
  end

  function automatic logic writable(input logic [7:0] c, input logic on);
    logic ok;
    ok = 1'b1;
    // Frequency only while disabled and in 400-1000kHz
    if (c == `CMD_SWITCH_FREQ)
      ok = !on;
    writable = ok;
  endfunction

  logic freq_ok, droop_ok, ceil_ok;
  assign freq_ok = l11_int(wr_val) >= 32'(`FREQ_MIN_KHZ) && l11_int(wr_val) <= 32'(`FREQ_MAX_KHZ);
  assign droop_ok = l11_int(wr_val) >= 0 && l11_int(wr_val) <= 32'(`DROOP_MAX_MV);
  assign ceil_ok = wr_val <= `VOLT_FOUR;

  // Store engine, busy timer for store commands only; restores take effect at once
  pmbus_output_pkg::mem_state_e mem_q;
  logic [31:0] busy_cnt_q;
  logic restore_pulse;
  logic init_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_q <= pmbus_output_pkg::mem_idle;
      busy_cnt_q <= 32'h0;
    end
    else if (mem_q == pmbus_output_pkg::mem_idle)
    begin
      if (wr_send && (cmd_q == `CMD_STORE_DEFAULT || cmd_q == `CMD_STORE_USER))
      begin
        mem_q <= pmbus_output_pkg::mem_store;
        busy_cnt_q <= BUSY_CYCLES;
      end
    end
    else if (busy_cnt_q <= 32'h1)
      mem_q <= pmbus_output_pkg::mem_idle;
    else
      busy_cnt_q <= busy_cnt_q - 32'h1;
  end
  assign busy = mem_q != pmbus_output_pkg::mem_idle;
  assign restore_pulse = 1'b0;

  // Default and user stores, cleared by reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      user_valid_q <= 1'b0;
      dflt_valid_q <= 1'b0;
      onoff_dflt_q <= `RST_ON_OFF_CONTROL;
      src_dflt_q <= `RST_ON_OFF_SOURCE;
      onoff_user_q <= `RST_ON_OFF_CONTROL;
      src_user_q <= `RST_ON_OFF_SOURCE;
      for (int i = 0; i < NREG; i++)
      begin
        dflt_q[i] <= 16'h0000;
        user_q[i] <= 16'h0000;
      end
    end
    else if (wr_send && !busy && cmd_q == `CMD_STORE_DEFAULT)
    begin
      dflt_valid_q <= 1'b1;
      onoff_dflt_q <= onoff_q;
      src_dflt_q <= src_q;
      for (int i = 0; i < NREG; i++)
        dflt_q[i] <= regs_q[i];
    end
    else if (wr_send && !busy && cmd_q == `CMD_STORE_USER)
    begin
      user_valid_q <= 1'b1;
      onoff_user_q <= onoff_q;
      src_user_q <= src_q;
      for (int i = 0; i < NREG; i++)
        user_q[i] <= regs_q[i];
    end
  end

  // Operating registers, power-up load and command writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_q <= 1'b1;
      onoff_q <= `RST_ON_OFF_CONTROL;
      src_q <= `RST_ON_OFF_SOURCE;
      security_level <= 2'h1;
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= 16'h0000;
    end
    else if (init_q)
    begin
      // Strap defaults, then default store, then user store
      init_q <= 1'b0;
      regs_q[I_TGT] <= strap_voltage;
      regs_q[I_TRIM] <= `RST_TRIM;
      regs_q[I_CAL] <= `RST_TRIM;
      regs_q[I_MAX] <= sat16(strap_110);
      regs_q[I_MH] <= sat16(strap_105);
      regs_q[I_ML] <= sat16(strap_095);
      regs_q[I_SLEW] <= `RST_SLEW_RATE;
      regs_q[I_DROOP] <= `RST_LOAD_LINE;
      regs_q[I_DUTY] <= `RST_DUTY_LIMIT;
      regs_q[I_FREQ] <= strap_frequency;
      regs_q[I_ILV] <= strap_phase_group_placement;
      if (user_valid_q)
        for (int i = 0; i < NREG; i++)
          regs_q[i] <= user_q[i];
      else if (dflt_valid_q)
        for (int i = 0; i < NREG; i++)
          regs_q[i] <= dflt_q[i];
    end
    else if (wr_send && !busy && cmd_q == `CMD_RESTORE_DEFAULT && dflt_valid_q)
    begin
      onoff_q <= onoff_dflt_q;
      src_q <= src_dflt_q;
      security_level <= 2'h1;
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= dflt_q[i];
    end
    else if (wr_send && !busy && cmd_q == `CMD_RESTORE_USER && user_valid_q)
    begin
      onoff_q <= onoff_user_q;
      src_q <= src_user_q;
      security_level <= 2'h1;
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= user_q[i];
    end
    else if ((wr_send && !busy) && (cmd_q == `CMD_RESTORE_DEFAULT || cmd_q == `CMD_RESTORE_USER))
      security_level <= 2'h1;
    else if (wr_byte && !busy)
    begin
      if (cmd_q == `CMD_ON_OFF_CONTROL)
        onoff_q <= lo_q;
      else if (cmd_q == `CMD_ON_OFF_SOURCE)
        src_q <= lo_q;
    end
    else if (wr_word && !busy && writable(cmd_q, output_on))
    begin
      unique case (cmd_q)
        `CMD_TARGET_VOLTAGE: regs_q[I_TGT] <= tgt_cap;
        `CMD_VOLTAGE_CEILING: if (ceil_ok) regs_q[I_MAX] <= wr_val;
        `CMD_SWITCH_FREQ: if (freq_ok) regs_q[I_FREQ] <= wr_val;
        `CMD_LOAD_LINE: if (droop_ok) regs_q[I_DROOP] <= wr_val;
        `CMD_VOLTAGE_TRIM, `CMD_CAL_OFFSET, `CMD_MARGIN_HIGH, `CMD_MARGIN_LOW,
        `CMD_SLEW_RATE, `CMD_DUTY_LIMIT: regs_q[cmd_index(cmd_q)] <= wr_val;
        `CMD_PHASE_GROUP: regs_q[I_ILV] <= {4'h0, wr_val[11:0]};
        default: ;
      endcase
    end
  end

  // On/off source and command interpretation
  logic cmd_on, cmd_soft;
  pmbus_output_pkg::vsel_e vsel;
  always_comb
  begin
    cmd_on = 1'b0;
    cmd_soft = 1'b0;
    vsel = pmbus_output_pkg::level_nominal;
    unique case (onoff_q)
      `OP_IMMEDIATE_OFF: cmd_on = 1'b0;
      `OP_SOFT_OFF: cmd_soft = 1'b1;
      `OP_ON_NOMINAL: cmd_on = 1'b1;
      `OP_ON_MARGIN_LOW:
      begin
        cmd_on = 1'b1;
        vsel = pmbus_output_pkg::level_low;
      end
      `OP_ON_MARGIN_HIGH:
      begin
        cmd_on = 1'b1;
        vsel = pmbus_output_pkg::level_high;
      end
      default: cmd_on = 1'b0;
    endcase
  end

  logic en_q, pw_q;
  logic [1:0] en_s_q, pw_s_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_s_q <= 2'h0;
      pw_s_q <= 2'h0;
    end
    else
    begin
      en_s_q <= {en_s_q[0], enable_pin};
      pw_s_q <= {pw_s_q[0], power_present};
    end
  end
  assign en_q = en_s_q[1];
  assign pw_q = pw_s_q[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      output_on <= 1'b0;
      immediate_off <= 1'b0;
    end
    else if (!pw_q || init_q)
      output_on <= 1'b0;
    else
    begin
      unique case (src_q)
        `SRC_ALWAYS_ON: output_on <= 1'b1;
        `SRC_PIN_SOFT:
        begin
          output_on <= en_q;
          immediate_off <= 1'b0;
        end
        `SRC_PIN_IMMEDIATE:
        begin
          output_on <= en_q;
          immediate_off <= 1'b1;
        end
        `SRC_COMMAND:
        begin
          output_on <= cmd_on;
          immediate_off <= !cmd_on && !cmd_soft;
        end
        default: output_on <= 1'b0;
      endcase
    end
  end

  // Setpoint slew toward selected target
  logic [15:0] aim, step;
  logic [7:0] tick_q;
  always_comb
  begin
    unique case (vsel)
      pmbus_output_pkg::level_low: aim = regs_q[I_ML];
      pmbus_output_pkg::level_high: aim = regs_q[I_MH];
      default: aim = regs_q[I_TGT];
    endcase
    if (aim > regs_q[I_MAX])
      aim = regs_q[I_MAX];
    // Rate in V/ms to LSB per microsecond, 8192 LSB per volt
    step = 16'((l11_int(regs_q[I_SLEW]) * 32'sd8192) / 32'sd1000);
    if (step == 16'h0)
      step = 16'h1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      voltage_setpoint <= 16'h0;
      tick_q <= 8'h0;
    end
    else if (regs_q[I_SLEW] == `SLEW_FASTEST || init_q)
      voltage_setpoint <= aim;
    else if (tick_q >= TICK_CYCLES - 8'h1)
    begin
      tick_q <= 8'h0;
      if (voltage_setpoint + step < aim && voltage_setpoint + step > voltage_setpoint)
        voltage_setpoint <= voltage_setpoint + step;
      else if (voltage_setpoint > aim + step)
        voltage_setpoint <= voltage_setpoint - step;
      else
        voltage_setpoint <= aim;
    end
    else
      tick_q <= tick_q + 8'h1;
  end

  assign voltage_offset = 17'(signed'(regs_q[I_TRIM])) + 17'(signed'(regs_q[I_CAL]));
  assign droop_setting = regs_q[I_DROOP];
  assign duty_limit = regs_q[I_DUTY];
  assign frequency_setting = regs_q[I_FREQ];
  assign group_number = regs_q[I_ILV][11:8];
  assign group_position = regs_q[I_ILV][3:0];
  assign rails_in_group = (regs_q[I_ILV][7:4] == 4'h0) ? 5'd16 : {1'b0, regs_q[I_ILV][7:4]};

  // Sticky faults, set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_status <= 8'h0;
    else if (wr_send && !busy && cmd_q == `CMD_CLEAR_FAULTS)
      fault_status <= fault_conditions;
    else
      fault_status <= fault_status | fault_conditions;
  end

  // Read data select
  logic [15:0] rd_word;
  always_comb
  begin
    unique case (cmd_q)
      `CMD_ON_OFF_CONTROL: rd_word = {8'h0, onoff_q};
      `CMD_ON_OFF_SOURCE: rd_word = {8'h0, src_q};
      `CMD_VOLTAGE_MODE: rd_word = {8'h0, `VOLTAGE_MODE_VALUE};
      default: rd_word = (cmd_index(cmd_q) == I_SPARE) ? 16'h0 : regs_q[cmd_index(cmd_q)];
    endcase
  end

  // SMBus slave, silent while storing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_q <= pmbus_output_pkg::rx_idle;
      bit_q <= 4'h0;
      sh_q <= 8'h0;
      cmd_q <= 8'h0;
      lo_q <= 8'h0;
      hi_q <= 8'h0;
      addr_ok_q <= 1'b0;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      in_frame_q <= 1'b0;
      send_q <= 1'b0;
      sending_q <= 1'b0;
      tx_q <= 16'h0;
      bytes_q <= 2'h0;
      sda_o <= 1'b1;
      sda_oe <= 1'b0;
    end
    else if (start_c)
    begin
      rx_q <= pmbus_output_pkg::rx_idle;
      bit_q <= 4'h0;
      in_frame_q <= 1'b1;
      addr_ok_q <= 1'b0;
      sending_q <= 1'b0;
      sda_oe <= 1'b0;
      bytes_q <= 2'h0;
    end
    else if (stop_c)
    begin
      in_frame_q <= 1'b0;
      send_q <= (rx_q == pmbus_output_pkg::rx_lo) && !rd_q;
      bytes_q <= 2'h0;
      rx_q <= pmbus_output_pkg::rx_idle;
      sda_oe <= 1'b0;
    end
    else
    begin
      send_q <= 1'b0;
      if (scl_rise && in_frame_q && bit_q < 4'd8)
      begin
        sh_q <= {sh_q[6:0], sda_s_q[1]};
        bit_q <= bit_q + 4'h1;
      end
      else if (scl_rise && bit_q == 4'd8)
      begin
        bit_q <= 4'h0;
        if (sending_q && sda_s_q[1])
          sending_q <= 1'b0;
      end
      if (scl_fall && bit_q == 4'd8 && !ack_q && !sending_q)
      begin
        ack_q <= 1'b1;
        unique case (rx_q)
          pmbus_output_pkg::rx_idle:
          begin
            if (sh_q[7:1] == bus_address && !busy)
            begin
              sda_oe <= 1'b1;
              sda_o <= 1'b0;
              rd_q <= sh_q[0];
              addr_ok_q <= 1'b1;
              rx_q <= pmbus_output_pkg::rx_cmd;
              if (sh_q[0])
              begin
                sending_q <= 1'b1;
                tx_q <= rd_word;
              end
            end
          end
          pmbus_output_pkg::rx_cmd:
          begin
            sda_oe <= 1'b1;
            sda_o <= 1'b0;
            cmd_q <= sh_q;
            rx_q <= pmbus_output_pkg::rx_lo;
          end
          pmbus_output_pkg::rx_lo:
          begin
            sda_oe <= 1'b1;
            sda_o <= 1'b0;
            lo_q <= sh_q;
            rx_q <= pmbus_output_pkg::rx_hi;
          end
          default:
          begin
            sda_oe <= 1'b1;
            sda_o <= 1'b0;
            bytes_q <= 2'h2;
            hi_q <= sh_q;
          end
        endcase
      end
      else if (scl_fall && ack_q)
      begin
        ack_q <= 1'b0;
        sda_oe <= sending_q;
        sda_o <= tx_q[7];
        if (sending_q)
          tx_q <= {tx_q[15:8], tx_q[6:0], 1'b0};
      end
      else if (scl_fall && sending_q && bit_q != 4'd8)
      begin
        sda_oe <= 1'b1;
        sda_o <= tx_q[7];
        tx_q <= {tx_q[15:8], tx_q[6:0], 1'b0};
        if (bit_q == 4'd7)
          tx_q <= {8'h0, tx_q[15:8]};
      end
      else if (scl_fall && sending_q && bit_q == 4'd8)
        sda_oe <= 1'b0;
      if (bytes_q == 2'h2)
        bytes_q <= 2'h3;
    end
  end
  assign wr_send = send_q && cmd_q != `CMD_ON_OFF_CONTROL;
  assign wr_byte = stop_c && rx_q == pmbus_output_pkg::rx_hi && !rd_q && bytes_q == 2'h0;
  assign wr_word = stop_c && bytes_q[1] && !rd_q;
endmodule

// ---- test/cmd_set_asserts.sv ----
// Port checker for the output command set
// Bound into every pmbus_output_command_set instance
`timescale 1ns/100ps
`include "pmbus_output_regs.svh"
module cmd_set_asserts
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sda_oe,
  input wire logic [7:0] fault_conditions,
  input wire logic [7:0] fault_status,
  input wire logic output_on,
  input wire logic [15:0] voltage_setpoint,
  input wire logic [15:0] frequency_setting,
  input wire logic [4:0] rails_in_group,
  input wire logic [1:0] security_level,
  input wire logic busy
);
  localparam int BusyMin = `STORE_BUSY_CYCLES - 2;
  logic [19:0] cnt_q;
  // Length of the current busy span
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 20'h00000;
    else
      cnt_q <= busy ? cnt_q + 20'h00001 : 20'h00000;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sec; security_level == 2'h1; endproperty
  a_sec: assert property (p_sec) else $error("security level");
  property p_cap; voltage_setpoint <= `VOLT_FOUR; endproperty
  a_cap: assert property (p_cap) else $error("setpoint cap");
  property p_freq; $changed(frequency_setting) |-> !$past(output_on); endproperty
  a_freq: assert property (p_freq) else $error("frequency while on");
  property p_rails; $past(rst_n) |-> rails_in_group != 5'h00 && rails_in_group <= 5'h10; endproperty
  a_rails: assert property (p_rails) else $error("rail count");
  property p_flt; $rose(fault_conditions[0]) |-> ##[1:4] fault_status[0]; endproperty
  a_flt: assert property (p_flt) else $error("fault not latched");
  property p_hold; $rose(busy) |-> busy [*8]; endproperty
  a_hold: assert property (p_hold) else $error("busy short");
  property p_span; $fell(busy) |-> cnt_q >= BusyMin; endproperty
  a_span: assert property (p_span) else $error("busy span");
  property p_mute; busy |-> !sda_oe; endproperty
  a_mute: assert property (p_mute) else $error("answered while busy");
endmodule
bind pmbus_output_command_set cmd_set_asserts u_asserts (.clk, .rst_n, .sda_oe, .fault_conditions,
  .fault_status, .output_on, .voltage_setpoint, .frequency_setting, .rails_in_group, .security_level, .busy);

// ---- test/host_model.sv ----
// Bus host that frames byte, word and send-byte commands
// Data line is pulled up; sda_low pulls it down
`timescale 1ns/100ps
module host_model
#(parameter logic [6:0] ADDR = 7'h2a)
(
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #50 scl = 1'b1;
    #100 s = sda;
    scl = 1'b0;
    #50;
  endtask
  task automatic byte_io(input logic [7:0] b, input logic a, output logic [7:0] r, output logic g);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r[i]);
    bit_io(a, g);
  endtask
  task automatic start();
    sda_low = 1'b0;
    #50 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
    #50;
  endtask
  // Low byte first on data bytes
  task automatic xfer(input logic [7:0] c, input int n, input logic [15:0] d, input logic rd,
                      output logic [15:0] q, output logic ok);
    logic [7:0] r;
    logic g0, g1;
    q = 16'h0000;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, r, g0);
    byte_io(c, 1'b1, r, g1);
    ok = !g0 && !g1;
    if (rd)
    begin
      start();
      byte_io({ADDR, 1'b1}, 1'b1, r, g1);
      ok = ok && !g1;
      for (int i = 0; i < n; i++)
      begin
        byte_io(8'hff, i == n - 1, r, g1);
        q[8*i +: 8] = r;
      end
    end
    else
      for (int i = 0; i < n; i++)
        byte_io(d[8*i +: 8], 1'b1, r, g1);
    sda_low = 1'b1;
    #50 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask
endmodule

// ---- test/testbench.sv ----
// Bench for the output command set with host model
// Straps and bus address held steady
`timescale 1ns/100ps
`include "pmbus_output_regs.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic pwr = 1'b1;
  logic [7:0] flt = 8'h00;
  logic scl, sda_low, sda, sda_o, sda_oe, output_on, immediate_off, busy;
  logic [15:0] voltage_setpoint, droop_setting, duty_limit, frequency_setting;
  logic signed [16:0] voltage_offset;
  logic [3:0] group_number, group_position;
  logic [4:0] rails_in_group;
  logic [1:0] security_level;
  logic [7:0] fault_status;
  int miscompares = 0;
  int compares = 0;
  assign sda = !(sda_low || (sda_oe && !sda_o));
  initial
  begin
    forever #12.5 clk = !clk;
  end
  pmbus_output_command_set DUT (.clk, .rst_n, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
    .bus_address(7'h2a), .enable_pin(en), .power_present(pwr), .strap_voltage(16'h2000),
    .strap_frequency(16'h0258), .strap_phase_group_placement(16'h0123), .fault_conditions(flt), .fault_status,
    .output_on, .immediate_off, .voltage_setpoint, .voltage_offset, .droop_setting, .duty_limit,
    .frequency_setting, .group_number, .rails_in_group, .group_position, .security_level, .busy);
  host_model host (.scl, .sda_low, .sda);
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pin(input logic v);
    @(posedge clk) en <= v;
    wait_clk(8);
  endtask
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    host.xfer(c, n, d, 1'b0, q, ok);
    wait_clk(8);
  endtask
  task automatic t_reset();
    logic [15:0] q;
    logic ok;
    host.xfer(`CMD_VOLTAGE_MODE, 1, 16'h0000, 1'b1, q, ok);
    `CHK("mode", 16'h0013, q)
    host.xfer(`CMD_VOLTAGE_CEILING, 2, 16'h0000, 1'b1, q, ok);
    `CHK("ceiling dflt", 16'h2333, q)
    host.xfer(`CMD_MARGIN_HIGH, 2, 16'h0000, 1'b1, q, ok);
    `CHK("high dflt", 16'h2199, q)
    host.xfer(`CMD_MARGIN_LOW, 2, 16'h0000, 1'b1, q, ok);
    `CHK("low dflt", 16'h1e66, q)
    `CHK("duty", `RST_DUTY_LIMIT, duty_limit)
    `CHK("droop", 16'h0000, droop_setting)
    `CHK("offset", 17'h00000, voltage_offset)
    `CHK("freq", 16'h0258, frequency_setting)
    `CHK("group", 13'h0223, {group_number, rails_in_group, group_position})
  endtask
  task automatic t_onoff();
    pin(1'b1);
    `CHK("pin on", 1'b1, output_on)
    pin(1'b0);
    `CHK("soft", 2'b00, {output_on, immediate_off})
    wr(`CMD_ON_OFF_SOURCE, 1, `SRC_PIN_IMMEDIATE);
    pin(1'b1);
    pin(1'b0);
    `CHK("hard", 2'b01, {output_on, immediate_off})
    wr(`CMD_ON_OFF_SOURCE, 1, `SRC_ALWAYS_ON);
    `CHK("always", 1'b1, output_on)
    @(posedge clk) pwr <= 1'b0;
    wait_clk(8);
    `CHK("no power", 1'b0, output_on)
    @(posedge clk) pwr <= 1'b1;
    wait_clk(8);
    wr(`CMD_ON_OFF_SOURCE, 1, `SRC_COMMAND);
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_IMMEDIATE_OFF);
    `CHK("op off", 2'b01, {output_on, immediate_off})
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_ON_NOMINAL);
    pin(1'b1);
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_SOFT_OFF);
    `CHK("op soft", 2'b00, {output_on, immediate_off})
  endtask
  task automatic t_margin();
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_ON_NOMINAL);
    wr(`CMD_SLEW_RATE, 2, `SLEW_FASTEST);
    wr(`CMD_MARGIN_HIGH, 2, 16'h2200);
    wr(`CMD_MARGIN_LOW, 2, 16'h1e00);
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_ON_MARGIN_HIGH); // Lone module is its own reference
    `CHK("high", 16'h2200, voltage_setpoint)
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_ON_MARGIN_LOW);
    `CHK("low", 16'h1e00, voltage_setpoint)
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_ON_NOMINAL);
    `CHK("nominal", 16'h2000, voltage_setpoint)
    wr(`CMD_VOLTAGE_CEILING, 2, 16'h2100);
    wr(`CMD_TARGET_VOLTAGE, 2, 16'h2800);
    `CHK("clamp", 16'h2100, voltage_setpoint)
    wr(`CMD_SWITCH_FREQ, 2, 16'h01f4);
    `CHK("freq on", 16'h0258, frequency_setting)
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_IMMEDIATE_OFF);
    wr(`CMD_SWITCH_FREQ, 2, 16'h01f4);
    wr(`CMD_SWITCH_FREQ, 2, 16'h044c);
    `CHK("freq off", 16'h01f4, frequency_setting)
  endtask
  task automatic t_misc();
    wr(`CMD_VOLTAGE_TRIM, 2, 16'h0200);
    wr(`CMD_CAL_OFFSET, 2, 16'hff00);
    `CHK("sum", 17'h00100, voltage_offset)
    wr(`CMD_LOAD_LINE, 2, 16'h0028);
    wr(`CMD_LOAD_LINE, 2, 16'h0029);
    `CHK("droop max", 16'h0028, droop_setting)
    wr(`CMD_PHASE_GROUP, 2, 16'h0305);
    `CHK("place", 13'h0705, {group_number, rails_in_group, group_position})
  endtask
  task automatic t_fault();
    @(posedge clk) flt <= 8'h01;
    wait_clk(6);
    @(posedge clk) flt <= 8'h02;
    wait_clk(6);
    `CHK("sticky", 8'h03, fault_status)
    wr(`CMD_CLEAR_FAULTS, 0, 16'h0000);
    `CHK("cleared", 8'h02, fault_status)
    `CHK("no restart", 1'b0, output_on)
  endtask
  task automatic t_store();
    logic [15:0] q;
    logic ok;
    wr(`CMD_ON_OFF_CONTROL, 1, `OP_ON_NOMINAL);
    wr(`CMD_STORE_USER, 0, 16'h0000);
    `CHK("busy", 1'b1, busy)
    host.xfer(`CMD_VOLTAGE_MODE, 1, 16'h0000, 1'b1, q, ok);
    `CHK("mute", 1'b0, ok)
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    wait_clk(3);
    rst_n <= 1'b1;
    wait_clk(6);
    t_reset();
    t_onoff();
    t_margin();
    t_misc();
    t_fault();
    t_store();
    give_verdict();
  end
  initial
  begin
    #2000000;
    miscompares++;
    give_verdict();
  end
endmodule
